// ---- core/isxu_pkg.sv ----
// shared constants, enums and carriers of the instruction subset execute unit
package isxu_pkg;

    // ------------------------------------------------------------
    // file addresses that are served inside the unit
    // ------------------------------------------------------------
    localparam logic [7:0] FA_PCL = 8'h02;
    localparam logic [7:0] FA_UPPER_PC_HOLDING_LATCH = 8'h03;
    localparam logic [7:0] FA_ASTAT = 8'h04;

    // ------------------------------------------------------------
    // arith status flag positions
    // ------------------------------------------------------------
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF_NIBBLE_CARRY = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SIGNED_RANGE = 3;

    // ------------------------------------------------------------
    // axi4-lite register byte offsets and responses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_WACC = 8'h04;
    localparam logic [7:0] REG_ASTAT = 8'h08;
    localparam logic [7:0] REG_UPPER_PC_HOLDING_LATCH = 8'h0c;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] WACC_RST = 8'h00;
    localparam logic [7:0] ASTAT_RST = 8'h00;
    localparam logic [7:0] UPPER_PC_HOLDING_LATCH_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    // ------------------------------------------------------------
    // enums and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } isxu_phase_t;

    typedef enum logic [2:0] {
        OP_NOP = 3'b000,
        OP_SET_BIT = 3'b001,
        OP_TEST_SKIP_CLEAR = 3'b010,
        OP_INC_SKIP_NZ = 3'b011,
        OP_OR_LIT = 3'b100,
        OP_SUB = 3'b101,
        OP_SUB_BORROW = 3'b110
    } isxu_op_t;

    typedef struct packed {
        logic [7:0] val;
        logic [3:0] flags;
        logic [3:0] upd;
        logic skip;
        logic wr;
        logic to_file;
    } isxu_alu_res_t;

    typedef struct packed {
        logic [7:0] addr;
        logic re;
        logic we;
        logic [7:0] wdata;
    } isxu_file_req_t;

endpackage

// ---- core/isxu_alu.sv ----
// combinational datapath of the instruction subset execute unit
`timescale 1ns/1ns
`default_nettype none
module isxu_alu
    import isxu_pkg::*;
(
    input wire isxu_op_t i_op,
    input wire logic [7:0] i_opnd,
    input wire logic [7:0] i_wacc,
    input wire logic [7:0] i_lit,
    input wire logic [2:0] i_bsel,
    input wire logic i_dbit,
    input wire logic i_carry,
    output isxu_alu_res_t o_res
);
    // ------------------------------------------------------------
    // shared arithmetic
    // ------------------------------------------------------------
    // subtract as f + ~w + cin, so carry comes out as inverted borrow
    logic cin;
    logic [8:0] diff9;
    logic [4:0] low5;
    logic [7:0] bit_mask;
    assign cin = (i_op == OP_SUB) ? 1'b1 : i_carry;
    assign diff9 = {1'b0, i_opnd} + {1'b0, ~i_wacc} + {8'h00, cin};
    assign low5 = {1'b0, i_opnd[3:0]} + {1'b0, ~i_wacc[3:0]} + {4'h0, cin};
    assign bit_mask = 8'h01 << i_bsel;

    // result, flag and write selection per operation
    always_comb begin
        o_res = '0;
        unique case (i_op)
            OP_SET_BIT: begin
                o_res.val = i_opnd | bit_mask;
                o_res.wr = 1'b1;
                o_res.to_file = 1'b1;
            end
            OP_TEST_SKIP_CLEAR: begin
                o_res.val = i_opnd;
                o_res.skip = ~|(i_opnd & bit_mask);
            end
            OP_INC_SKIP_NZ: begin
                o_res.val = i_opnd + 8'h01;
                o_res.skip = |o_res.val;
                o_res.wr = 1'b1;
                o_res.to_file = i_dbit;
            end
            OP_OR_LIT: begin
                o_res.val = i_wacc | i_lit;
                o_res.flags[FLAG_ZERO] = ~|o_res.val;
                o_res.upd[FLAG_ZERO] = 1'b1;
                o_res.wr = 1'b1;
            end
            OP_SUB, OP_SUB_BORROW: begin
                o_res.val = diff9[7:0];
                o_res.flags[FLAG_CARRY] = diff9[8];
                o_res.flags[FLAG_HALF_NIBBLE_CARRY] = low5[4];
                o_res.flags[FLAG_ZERO] = ~|diff9[7:0];
                o_res.flags[FLAG_SIGNED_RANGE] = (i_opnd[7] ^ i_wacc[7])
                    & (diff9[7] ^ i_opnd[7]);
                o_res.upd = 4'hf;
                o_res.wr = 1'b1;
                o_res.to_file = i_dbit;
            end
            default: begin
                o_res = '0;
            end
        endcase
    end
endmodule // isxu_alu
`default_nettype wire

// ---- core/isxu_core.sv ----
// four-phase execute unit for a subset of the 8-bit instruction set
// Notes on behaviour
// - own flag updates override the same bits written into arith_status_reg
// - pcl read copies high byte to latch unless the same instruction writes pcl; pcl write loads high byte from latch
// - program counter high byte is internal, reached only through the holding latch
// - set-bit reads all eight bits, changes one, writes all eight back; test-bit only reads
// - hardware set/clear of status flags happens only in first quarter phase
// - set-bit forces bit b of file f high, flags untouched, one cycle
// - test-bit skips prefetched instruction with an idle cycle when bit clear
// - increment to destination, skip when sum nonzero, flags untouched
// - destination bit 0 selects accumulator, 1 selects file register
// - subtract computes f minus accumulator, updates four flags, one cycle
// - subtract with borrow also subtracts inverted carry, updates four flags
// - or-literal ors eight-bit literal into accumulator, only zero flag changes
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module isxu_core
    import isxu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [3:0] i_hw_flag_set,
    input wire logic [3:0] i_hw_flag_clr,
    input wire logic [7:0] i_file_rdata,
    output isxu_file_req_t o_file
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    isxu_phase_t phase_reg;
    logic pend_reg;
    logic [15:0] pend_instr_reg;
    logic [15:0] ir_reg;
    logic active_reg;
    logic cyc_reg;
    logic skip_reg;
    logic int_src_reg;
    logic [7:0] opnd_int_reg;
    isxu_alu_res_t res_reg;
    logic [3:0] hwset_reg;
    logic [3:0] hwclr_reg;
    logic [7:0] working_accumulator_reg;
    logic [7:0] arith_status_reg;
    logic [7:0] program_counter_low_reg;
    logic [7:0] program_counter_high_reg;
    logic [7:0] upper_pc_holding_latch_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wlane0_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic isxu_op_t decode(input logic [15:0] w);
        isxu_op_t op;
        op = OP_NOP;
        if (w[15:11] == 5'b10000) op = OP_SET_BIT;
        else if (w[15:11] == 5'b10011) op = OP_TEST_SKIP_CLEAR;
        else if (w[15:9] == 7'b0010010) op = OP_INC_SKIP_NZ;
        else if (w[15:8] == 8'hb3) op = OP_OR_LIT;
        else if (w[15:9] == 7'b0000010) op = OP_SUB;
        else if (w[15:9] == 7'b0000001) op = OP_SUB_BORROW;
        return op;
    endfunction

    function automatic logic is_internal(input logic [7:0] a);
        return (a == FA_PCL) || (a == FA_UPPER_PC_HOLDING_LATCH) || (a == FA_ASTAT);
    endfunction

    isxu_op_t op_w;
    isxu_op_t pend_op_w;
    logic [7:0] f_addr;
    logic reads_f;
    logic pend_reads_f;
    logic q1;
    logic q2;
    logic q3;
    logic q4;
    logic consume;
    assign op_w = decode(ir_reg);
    assign pend_op_w = decode(pend_instr_reg);
    assign f_addr = ir_reg[7:0];
    assign reads_f = (op_w != OP_NOP) && (op_w != OP_OR_LIT);
    assign pend_reads_f = (pend_op_w != OP_NOP) && (pend_op_w != OP_OR_LIT);
    assign q1 = (phase_reg == PH_Q1);
    assign q2 = (phase_reg == PH_Q2);
    assign q3 = (phase_reg == PH_Q3);
    assign q4 = (phase_reg == PH_Q4);
    assign consume = q1 && pend_reg;

    // ------------------------------------------------------------
    // operand and datapath
    // ------------------------------------------------------------
    // internal registers answer in q2; outside file answers in q3
    logic [7:0] int_val;
    logic [7:0] opnd_w;
    isxu_alu_res_t alu_res;
    assign int_val = (f_addr == FA_PCL) ? program_counter_low_reg :
        (f_addr == FA_UPPER_PC_HOLDING_LATCH) ? upper_pc_holding_latch_reg : arith_status_reg;
    assign opnd_w = int_src_reg ? opnd_int_reg : i_file_rdata;

    isxu_alu u_alu (
        .i_op(op_w),
        .i_opnd(opnd_w),
        .i_wacc(working_accumulator_reg),
        .i_lit(ir_reg[7:0]),
        .i_bsel(ir_reg[10:8]),
        .i_dbit(ir_reg[8]),
        .i_carry(arith_status_reg[FLAG_CARRY]),
        .o_res(alu_res)
    );

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    // writes land only in q1 so they never race instruction writes
    logic do_write;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_mapped;
    logic wr_instr;
    logic wr_wacc;
    logic wr_astat;
    logic wr_upper_pc_holding_latch;
    logic [31:0] rd_val;
    logic rd_mapped;
    assign do_write = aw_have_reg && w_have_reg && !o_bvalid && q1;
    assign aw_take = i_awvalid && o_awready;
    assign w_take = i_wvalid && o_wready;
    assign ar_take = i_arvalid && o_arready;
    assign wr_mapped = (awaddr_reg == REG_INSTR) || (awaddr_reg == REG_WACC)
        || (awaddr_reg == REG_ASTAT) || (awaddr_reg == REG_UPPER_PC_HOLDING_LATCH)
        || (awaddr_reg == REG_STATE);
    assign wr_instr = do_write && wlane0_reg && (awaddr_reg == REG_INSTR);
    assign wr_wacc = do_write && wlane0_reg && (awaddr_reg == REG_WACC);
    assign wr_astat = do_write && wlane0_reg && (awaddr_reg == REG_ASTAT);
    assign wr_upper_pc_holding_latch = do_write && wlane0_reg && (awaddr_reg == REG_UPPER_PC_HOLDING_LATCH);
    assign rd_mapped = (i_araddr == REG_INSTR) || (i_araddr == REG_WACC)
        || (i_araddr == REG_ASTAT) || (i_araddr == REG_UPPER_PC_HOLDING_LATCH)
        || (i_araddr == REG_STATE);
    assign rd_val = (i_araddr == REG_WACC) ? {24'h0, working_accumulator_reg} :
        (i_araddr == REG_ASTAT) ? {24'h0, arith_status_reg} :
        (i_araddr == REG_UPPER_PC_HOLDING_LATCH) ? {24'h0, upper_pc_holding_latch_reg} :
        (i_araddr == REG_STATE) ? {28'h0, skip_reg, pend_reg, phase_reg} : 32'h0;

    // channel handshakes, one write and one read in flight
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wlane0_reg <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= RESP_OKAY;
        end else begin
            aw_have_reg <= (aw_have_reg && !do_write) || aw_take;
            w_have_reg <= (w_have_reg && !do_write) || w_take;
            o_awready <= !((aw_have_reg && !do_write) || aw_take);
            o_wready <= !((w_have_reg && !do_write) || w_take);
            if (aw_take) awaddr_reg <= {i_awaddr[7:2], 2'b00};
            if (w_take) begin
                wdata_reg <= i_wdata;
                wlane0_reg <= i_wstrb[0];
            end
            o_bvalid <= do_write || (o_bvalid && !i_bready);
            if (do_write) o_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            o_rvalid <= ar_take || (o_rvalid && !i_rready);
            o_arready <= !(ar_take || (o_rvalid && !i_rready));
            if (ar_take) begin
                o_rdata <= rd_val;
                o_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // instruction sequencing
    // ------------------------------------------------------------
    // one 16-bit word is held; a write in q1 becomes the next word while the held word is taken
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_reg <= PH_Q1;
            pend_reg <= 1'b0;
            pend_instr_reg <= 16'h0;
        end else begin
            phase_reg <= isxu_phase_t'(phase_reg + 2'b01);
            pend_reg <= wr_instr || (pend_reg && !consume);
            if (wr_instr) pend_instr_reg <= wdata_reg[15:0];
        end
    end

    // one phase per stage, skip cycle idle throughout
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ir_reg <= 16'h0;
            active_reg <= 1'b0;
            cyc_reg <= 1'b0;
            skip_reg <= 1'b0;
            int_src_reg <= 1'b0;
            opnd_int_reg <= 8'h00;
            res_reg <= '0;
            o_file <= '0;
        end else begin
            o_file.re <= consume && !skip_reg && pend_reads_f
                && !is_internal(pend_instr_reg[7:0]);
            o_file.we <= q3 && active_reg && alu_res.wr && alu_res.to_file
                && !is_internal(f_addr);
            if (consume) begin
                ir_reg <= skip_reg ? 16'h0 : pend_instr_reg;
                active_reg <= !skip_reg;
                cyc_reg <= 1'b1;
                skip_reg <= 1'b0;
                o_file.addr <= pend_instr_reg[7:0];
            end
            if (q2) begin
                int_src_reg <= is_internal(f_addr);
                opnd_int_reg <= int_val;
            end
            if (q3) begin
                res_reg <= active_reg ? alu_res : '0;
                o_file.wdata <= alu_res.val;
            end
            if (q4) begin
                skip_reg <= skip_reg || (active_reg && res_reg.skip);
                active_reg <= 1'b0;
                cyc_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // architectural registers
    // ------------------------------------------------------------
    logic commit;
    logic wr_file_int;
    logic dest_astat;
    logic dest_pcl;
    logic dest_upper_pc_holding_latch;
    logic read_pcl;
    logic [7:0] astat_base;
    logic [7:0] astat_q4;
    logic [7:0] astat_q1;
    logic [15:0] pc_inc;
    assign commit = q4 && active_reg && res_reg.wr;
    assign wr_file_int = commit && res_reg.to_file;
    assign dest_astat = wr_file_int && (f_addr == FA_ASTAT);
    assign dest_pcl = wr_file_int && (f_addr == FA_PCL);
    assign dest_upper_pc_holding_latch = wr_file_int && (f_addr == FA_UPPER_PC_HOLDING_LATCH);
    // a read-modify-write of pcl must not refresh the latch it is about to load
    assign read_pcl = q2 && active_reg && reads_f && (f_addr == FA_PCL)
        && !(alu_res.wr && alu_res.to_file);
    // instruction flags override bits written to status
    assign astat_base = dest_astat ? res_reg.val : arith_status_reg;
    assign astat_q4 = (astat_base & ~{4'h0, res_reg.upd})
        | {4'h0, res_reg.flags & res_reg.upd};
    // hardware flag changes applied in q1, set beats clear
    assign astat_q1 = ((wr_astat ? wdata_reg[7:0] : arith_status_reg)
        & ~{4'h0, hwclr_reg & ~hwset_reg}) | {4'h0, hwset_reg};
    assign pc_inc = {program_counter_high_reg, program_counter_low_reg} + 16'h0001;

    // hardware flag requests wait for q1; a new request in q1 is kept
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hwset_reg <= 4'h0;
            hwclr_reg <= 4'h0;
        end else begin
            hwset_reg <= (q1 ? 4'h0 : hwset_reg) | i_hw_flag_set;
            hwclr_reg <= (q1 ? 4'h0 : hwclr_reg) | i_hw_flag_clr;
        end
    end

    // destination bit picks accumulator or file
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            working_accumulator_reg <= WACC_RST;
            arith_status_reg <= ASTAT_RST;
        end else begin
            if (commit && !res_reg.to_file) working_accumulator_reg <= res_reg.val;
            else if (wr_wacc) working_accumulator_reg <= wdata_reg[7:0];
            if (q4 && active_reg) arith_status_reg <= astat_q4;
            else if (q1) arith_status_reg <= astat_q1;
        end
    end

    // pcl read and write paths through the latch
    // high byte has no address of its own
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            program_counter_low_reg <= PC_RST[7:0];
            program_counter_high_reg <= PC_RST[15:8];
            upper_pc_holding_latch_reg <= UPPER_PC_HOLDING_LATCH_RST;
        end else begin
            if (read_pcl) upper_pc_holding_latch_reg <= program_counter_high_reg;
            else if (dest_upper_pc_holding_latch) upper_pc_holding_latch_reg <= res_reg.val;
            else if (wr_upper_pc_holding_latch) upper_pc_holding_latch_reg <= wdata_reg[7:0];
            if (dest_pcl) begin
                program_counter_low_reg <= res_reg.val;
                program_counter_high_reg <= upper_pc_holding_latch_reg;
            end else if (q4 && cyc_reg) begin
                program_counter_low_reg <= pc_inc[7:0];
                program_counter_high_reg <= pc_inc[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [2:0] bsel_w;
    assign bsel_w = ir_reg[10:8];
    logic ex3;
    assign ex3 = q3 && active_reg;

    property p_set_bit;
        ex3 && op_w == OP_SET_BIT && !is_internal(f_addr)
        |=> o_file.we && o_file.wdata == ($past(opnd_w) | (8'h01 << $past(bsel_w)));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("set-bit write wrong");

    property p_test_skip;
        ex3 && op_w == OP_TEST_SKIP_CLEAR && !opnd_w[bsel_w] |-> ##2 skip_reg;
    endproperty
    a_test_skip: assert property (p_test_skip) else $error("clear bit gave no skip");

    property p_skip_idle;
        q1 && skip_reg && pend_reg |=> (!active_reg && !o_file.re && !o_file.we) [*4];
    endproperty
    a_skip_idle: assert property (p_skip_idle) else $error("skip cycle not idle");

    property p_inc_skip;
        ex3 && op_w == OP_INC_SKIP_NZ
        |=> res_reg.val == $past(opnd_w) + 8'h01 && res_reg.skip == (|res_reg.val)
            && res_reg.upd == 4'h0;
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment result wrong");

    property p_sub_carry;
        ex3 && op_w == OP_SUB
        |=> res_reg.flags[FLAG_CARRY] == ($past(opnd_w) >= $past(working_accumulator_reg));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

    property p_sub_borrow;
        ex3 && op_w == OP_SUB_BORROW
        |=> res_reg.val == 8'($past(opnd_w) - $past(working_accumulator_reg)
            - {7'h0, !$past(arith_status_reg[FLAG_CARRY])});
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong");

    property p_or_lit;
        ex3 && op_w == OP_OR_LIT
        |-> ##2 working_accumulator_reg == ($past(working_accumulator_reg, 2) | $past(ir_reg[7:0], 2))
            && arith_status_reg[3:0] == {$past(arith_status_reg[3], 2), 1'b0 || ~|working_accumulator_reg,
            $past(arith_status_reg[1:0], 2)};
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("or-literal wrong");

    property p_astat_dest;
        dest_astat |=> arith_status_reg[3:0] ==
            (($past(res_reg.val[3:0]) & ~$past(res_reg.upd)) | ($past(res_reg.flags) & $past(res_reg.upd)));
    endproperty
    a_astat_dest: assert property (p_astat_dest) else $error("status write lost flags");

    property p_pcl_write;
        dest_pcl |=> program_counter_low_reg == $past(res_reg.val)
            && program_counter_high_reg == $past(upper_pc_holding_latch_reg);
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("pcl write wrong");

    property p_flag_phase;
        q2 || q3 |=> $stable(arith_status_reg);
    endproperty
    a_flag_phase: assert property (p_flag_phase) else $error("status changed mid-cycle");

    c_set_bit: cover property (ex3 && op_w == OP_SET_BIT);
    c_skip: cover property (q1 && skip_reg && pend_reg);
    c_pcl: cover property (dest_pcl);
endmodule // isxu_core
`default_nettype wire

// ---- sim/isxu_file_mem.sv ----
// file register model on the far side of the execute unit
`timescale 1ns/1ns
`default_nettype none
module isxu_file_mem
    import isxu_pkg::*;
(
    input wire logic i_clk,
    input wire isxu_file_req_t i_file,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];
    // ----
    // byte read one clock after the request
    // ----
    always @(posedge i_clk) begin
        o_rdata <= i_file.re ? mem[i_file.addr] : ~o_rdata; // stale data keeps moving
        if (i_file.we) mem[i_file.addr] <= i_file.wdata;
    end
endmodule // isxu_file_mem
`default_nettype wire

// ---- sim/isa_subset_execute_unit_tb.sv ----
// self-checking bench of the instruction subset execute unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module isa_subset_execute_unit_tb
    import isxu_pkg::*;
;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, i_file_rdata, w, st, f, k;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [1:0] o_bresp, o_rresp;
    logic [33:0] exq [$];
    logic [33:0] e;
    logic [7:0] sh [256];
    logic [2:0] b;
    logic skp = 1'b0;
    logic [3:0] hs = 4'h0, hc = 4'h0;
    logic [15:0] pc = 16'h0;
    isxu_file_req_t o_file;
    int n_errors = 0, cmp_count = 0, cyc = 0, seed = 66;
    isxu_core dut (.i_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb(4'hf), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .i_hw_flag_set(hs), .i_hw_flag_clr(hc), .i_file_rdata, .o_file);
    isxu_file_mem fm (.i_clk, .i_file(o_file), .o_rdata(i_file_rdata));
    always #5 i_clk = ~i_clk;
    // ----
    // read watcher and hang guard; negedge avoids edge races
    // ----
    always @(negedge i_clk) begin
        if (o_rvalid && i_rready) begin
            e = exq.pop_front();
            `CHK({o_rresp, o_rdata}, e)
        end
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, ok;
        @(posedge i_clk);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'b111};
        do begin
            @(negedge i_clk);
            {ta, tw, ok} = {o_awready && i_awvalid, o_wready && i_wvalid, o_bvalid};
            if (ok) `CHK(o_bresp, RESP_OKAY)
            @(posedge i_clk);
            {i_awvalid, i_wvalid, i_bready} <= {i_awvalid && !ta, i_wvalid && !tw, !ok};
        end while (!ok);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        logic ta, ok;
        @(posedge i_clk);
        exq.push_back(x);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'b11};
        do begin
            @(negedge i_clk);
            {ta, ok} = {o_arready && i_arvalid, o_rvalid};
            @(posedge i_clk);
            {i_arvalid, i_rready} <= {i_arvalid && !ta, !ok};
        end while (!ok);
    endtask
    // instruction word, then room for pending plus one four-phase cycle
    task automatic ex(input logic [15:0] ins);
        wr(REG_INSTR, {16'h0, ins});
        pc++;
        repeat (10) @(posedge i_clk);
    endtask
    task automatic regs();
        rd(REG_WACC, {RESP_OKAY, 24'h0, w});
        rd(REG_ASTAT, {RESP_OKAY, 24'h0, st});
    endtask
    // subtract model: result, then signed range, zero, half nibble, carry
    task automatic sub(input logic bw, input logic d, input logic [7:0] fa);
        logic [8:0] r;
        logic [4:0] h;
        logic [7:0] a;
        a = fa == FA_ASTAT ? st : fa == FA_PCL ? pc[7:0] : sh[fa];
        r = {1'b0, a} - {1'b0, w} - {8'h0, bw && !st[FLAG_CARRY]};
        h = {1'b0, a[3:0]} - {1'b0, w[3:0]} - {4'h0, bw && !st[FLAG_CARRY]};
        ex({5'b00000, !bw, bw, d, fa});
        st = {fa == FA_ASTAT ? r[7:4] : st[7:4], (a[7] != w[7]) && (r[7] != a[7]),
            r[7:0] == 8'h00, !h[4], !r[8]};
        if (!d) w = r[7:0];
        else if (fa != FA_ASTAT) sh[fa] = r[7:0];
    endtask
    task automatic ior(input logic [7:0] kk);
        ex({8'hb3, kk});
        if (!skp) {w, st[FLAG_ZERO]} = {w | kk, (w | kk) == 8'h00};
        skp = 1'b0;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        for (int i = 0; i < 256; i++) begin
            sh[i] = 8'($random(seed));
            fm.mem[i] = sh[i];
        end
        {w, st} = {WACC_RST, ASTAT_RST};
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(REG_UPPER_PC_HOLDING_LATCH, {RESP_OKAY, 24'h0, UPPER_PC_HOLDING_LATCH_RST});
        rd(8'h20, {RESP_SLVERR, 32'h0});
        repeat (4) begin
            {f, b, k, w} = {8'h10 | 8'($random(seed)), 3'($random(seed)), 16'($random(seed))};
            wr(REG_WACC, {24'h0, w});
            sub(1'b0, 1'b0, f);
            regs();
            sub(1'b1, 1'b1, f);
            ex({5'b10000, b, f});
            sh[f][b] = 1'b1;
            ex({8'h24, f});
            {w, skp} = {sh[f] + 8'h01, sh[f] != 8'hff};
            ior(k);
            regs();
            b = 3'($random(seed));
            ex({5'b10011, b, f});
            skp = !sh[f][b];
            ior(~k);
            regs();
            sub(1'b0, 1'b1, FA_ASTAT);
            regs();
            // hardware flag pulse between instructions, set beats clear
            {hs, hc} <= 8'($random(seed));
            @(posedge i_clk);
            st[3:0] = (st[3:0] & ~(hc & ~hs)) | hs;
            {hs, hc} <= 8'h00;
            repeat (5) @(posedge i_clk);
            regs();
        end
        // pcl write loads high byte from latch, pcl read refreshes latch
        k = 8'($random(seed));
        wr(REG_UPPER_PC_HOLDING_LATCH, {24'h0, k});
        f = pc[7:0];
        ex({5'b10000, 3'h7, FA_PCL});
        pc = {k, f | 8'h80};
        sub(1'b0, 1'b0, FA_PCL);
        rd(REG_UPPER_PC_HOLDING_LATCH, {RESP_OKAY, 24'h0, k});
        regs();
        complete_run();
    end
endmodule // isa_subset_execute_unit_tb
`default_nettype wire
